// ---- rtl/fprs_stack.sv ----
// Eight-entry circular floating-point register stack with status word.
`timescale 1ns/1ps
`default_nettype none
module fprs_stack
   import fprs_pkg::*;
(
   input  wire logic              mclk,        // Core clock.
   input  wire logic              rst,         // Async reset, high.
   input  wire fprs_op_t          op,          // Operation this cycle.
   input  wire logic [PTR_W-1:0]  rel_idx,     // Stack-relative index.
   input  wire fprs_fmt_t         fmt,         // Memory operand format.
   input  wire logic [MEM_W-1:0]  mem_wdata,   // Operand from memory.
   output logic [MEM_W-1:0]       mem_rdata,   // Operand to memory.
   output logic                   mem_rvalid,  // Operand to memory valid.
   output logic [SW_W-1:0]        fp_status_word, // Live status word.
   output logic [SW_W-1:0]        integer_accumulator, // Status copy.
   output logic                   acc_wr,      // Accumulator write pulse.
   output logic                   stack_fault_exception, // Fault pulse.
   input  wire logic              pk_wr,       // Packed view write.
   input  wire logic [PTR_W-1:0]  pk_idx,      // Packed view register.
   input  wire logic [PK_W-1:0]   pk_wdata,    // Packed view data.
   output logic [PK_W-1:0]        pk_rdata,    // Packed view read.
   input  wire logic              mode_wide    // Wide/compat mode flag.
);
   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [DATA_W-1:0]   regs_q [DEPTH];  // Physical data registers.
   logic [DEPTH-1:0]    tag_q;           // Occupancy, one per register.
   logic [PTR_W-1:0]    top_q;           // Stack-top pointer.
   logic [SW_EXC_W-1:0] exc_q;           // Sticky exception flags.
   logic                sf_q;            // Stack fault flag.
   logic                c1_q;            // condition_bit_one.
   logic [PTR_W-1:0]    top_dec;         // Pointer after a push.
   logic [PTR_W-1:0]    phys;            // Physical register of rel_idx.
   logic                ovf;             // Push onto occupied register.
   logic                unf;             // Read of an empty register.
   logic                fault;           // Either fault this cycle.

   fprs_cnv_if cv ();

   fprs_conv u_conv (
      .cv (cv)
   );

   // Map a stack-relative index to a physical register number.
   function automatic logic [PTR_W-1:0] rel2phys(
      input logic [PTR_W-1:0] t,
      input logic [PTR_W-1:0] i
   );
      rel2phys = PTR_W'(t + i);
   endfunction

   // ----------------------------------------------------------------
   // Addressing and fault detection
   // ----------------------------------------------------------------
   // The mode flag is accepted but does not alter behaviour in any mode.
   // Only this block's own state is touched; no other state is read.
   always_comb begin
      top_dec = PTR_W'(top_q - PTR_ONE);
      phys    = rel2phys(top_q, rel_idx);
      ovf     = 1'b0;
      unf     = 1'b0;
      case (op)
         FPRS_OP_PUSH: begin
            ovf = tag_q[top_dec];
         end
         FPRS_OP_POP: begin
            unf = !tag_q[top_q];
         end
         FPRS_OP_STORE: begin
            unf = !tag_q[phys];
         end
         FPRS_OP_SWAP: begin
            unf = !tag_q[top_q] || !tag_q[phys];
         end
         default: begin
            ovf = 1'b0;
         end
      endcase
      fault = ovf || unf;
   end

   // Converter hookup: inbound memory operand, outbound register value.
   assign cv.ld_raw = mem_wdata;
   assign cv.ld_fmt = fmt;
   assign cv.st_fmt = fmt;
   assign cv.st_ext = (op == FPRS_OP_POP) ? regs_q[top_q] : regs_q[phys];

   // ----------------------------------------------------------------
   // Stack-top pointer
   // ----------------------------------------------------------------
   // A faulting push or pop leaves the pointer where it is.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         top_q <= TOP_RST;
      end else if (op == FPRS_OP_PUSH && !fault) begin
         top_q <= top_dec;
      end else if (op == FPRS_OP_POP && !fault) begin
         top_q <= PTR_W'(top_q + PTR_ONE);
      end
   end

   // ----------------------------------------------------------------
   // Data registers and occupancy
   // ----------------------------------------------------------------
   // Registers hold no reset value; occupancy marks them empty instead.
   always_ff @(posedge mclk) begin
      if (!rst) begin
         if (op == FPRS_OP_PUSH && !fault) begin
            regs_q[top_dec] <= cv.ld_ext;
         end else if (op == FPRS_OP_LOAD) begin
            regs_q[phys] <= cv.ld_ext;
         end else if (op == FPRS_OP_SWAP && !fault) begin
            regs_q[top_q] <= regs_q[phys];
            regs_q[phys]  <= regs_q[top_q];
         end else if (pk_wr) begin
            // The packed view writes the low word; exponent goes all ones.
            regs_q[pk_idx] <= {1'b1, EXP_MAX, pk_wdata};
         end
      end
   end

   // Occupancy follows pushes, loads, pops and packed writes made while op is FPRS_OP_NONE.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tag_q <= TAG_EMPTY;
      end else if (op == FPRS_OP_PUSH && !fault) begin
         tag_q[top_dec] <= 1'b1;
      end else if (op == FPRS_OP_LOAD) begin
         tag_q[phys] <= 1'b1;
      end else if (op == FPRS_OP_POP && !fault) begin
         tag_q[top_q] <= 1'b0;
      end else if (pk_wr && op == FPRS_OP_NONE) begin
         tag_q[pk_idx] <= 1'b1;
      end
   end

   // The packed view reads the low 64 bits of the same registers.
   assign pk_rdata = regs_q[pk_idx][PK_W-1:0];

   // ----------------------------------------------------------------
   // Memory read data
   // ----------------------------------------------------------------
   // Pop stores read the old top before the pointer moves.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         mem_rdata  <= '0;
         mem_rvalid <= 1'b0;
      end else begin
         mem_rvalid <= 1'b0;
         if ((op == FPRS_OP_POP || op == FPRS_OP_STORE) && !fault) begin
            mem_rdata  <= cv.st_raw;
            mem_rvalid <= 1'b1;
         end else if (op == FPRS_OP_STSW) begin
            mem_rdata  <= {64'h0, fp_status_word};
            mem_rvalid <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status word flags
   // ----------------------------------------------------------------
   // A fault in the same cycle as a clear wins over the clear.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         exc_q <= EXC_RST;
         sf_q  <= 1'b0;
         c1_q  <= 1'b0;
      end else if (fault) begin
         exc_q <= exc_q | IE_BIT;
         sf_q  <= 1'b1;
         c1_q  <= ovf;
      end else if (op == FPRS_OP_CLEX) begin
         exc_q <= EXC_RST;
         sf_q  <= 1'b0;
      end
   end

   // Assemble the status word; unmodelled condition bits read zero.
   always_comb begin
      fp_status_word = '0;
      fp_status_word[SW_EXC_W-1:0] = exc_q;
      fp_status_word[SW_SF] = sf_q;
      fp_status_word[SW_ES] = |exc_q;
      fp_status_word[SW_C1] = c1_q;
      fp_status_word[SW_TOP_HI:SW_TOP_LO] = top_q;
      fp_status_word[SW_B]  = |exc_q;
   end

   // ----------------------------------------------------------------
   // Accumulator copy and fault pulse
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         integer_accumulator   <= '0;
         acc_wr                <= 1'b0;
         stack_fault_exception <= 1'b0;
      end else begin
         acc_wr                <= (op == FPRS_OP_STSW);
         stack_fault_exception <= fault;
         if (op == FPRS_OP_STSW) begin
            integer_accumulator <= fp_status_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_push_ok;
      op == FPRS_OP_PUSH && !fault;
   endsequence
   property p_push_dec;
      @(posedge mclk) disable iff (rst)
      s_push_ok |=> top_q == PTR_W'($past(top_q) - PTR_ONE);
   endproperty
   a_push_dec: assert property (p_push_dec)
      else $error("push did not decrement top");
   property p_wrap;
      @(posedge mclk) disable iff (rst)
      (s_push_ok and top_q == 3'h0) |=> top_q == 3'h7;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("push from zero did not wrap to seven");
   property p_pop_inc;
      @(posedge mclk) disable iff (rst)
      (op == FPRS_OP_POP && !fault) |=>
         top_q == PTR_W'($past(top_q) + PTR_ONE) && mem_rvalid;
   endproperty
   a_pop_inc: assert property (p_pop_inc)
      else $error("pop did not store and increment");
   property p_top_field;
      @(posedge mclk) disable iff (rst)
      fp_status_word[SW_TOP_HI:SW_TOP_LO] == top_q;
   endproperty
   a_top_field: assert property (p_top_field)
      else $error("status top field mismatch");
   property p_ovf_c1;
      @(posedge mclk) disable iff (rst)
      (fault && ovf) |=> fp_status_word[SW_C1] && fp_status_word[SW_SF];
   endproperty
   a_ovf_c1: assert property (p_ovf_c1)
      else $error("overflow did not set condition bit one");
   property p_unf_c1;
      @(posedge mclk) disable iff (rst)
      (fault && !ovf) |=> !fp_status_word[SW_C1] && stack_fault_exception;
   endproperty
   a_unf_c1: assert property (p_unf_c1)
      else $error("underflow did not clear condition bit one");
   property p_ovf_detect;
      @(posedge mclk) disable iff (rst)
      (op == FPRS_OP_PUSH && tag_q[PTR_W'(top_q - PTR_ONE)]) |=>
         stack_fault_exception && $stable(top_q);
   endproperty
   a_ovf_detect: assert property (p_ovf_detect)
      else $error("push onto occupied register not faulted");
   property p_stsw;
      @(posedge mclk) disable iff (rst)
      op == FPRS_OP_STSW |=>
         acc_wr && integer_accumulator == $past(fp_status_word);
   endproperty
   a_stsw: assert property (p_stsw)
      else $error("status copy to accumulator wrong");
   property p_swap;
      @(posedge mclk) disable iff (rst)
      (op == FPRS_OP_SWAP && !fault && !pk_wr) |=>
         regs_q[top_q] == $past(regs_q[phys]);
   endproperty
   a_swap: assert property (p_swap)
      else $error("swap did not exchange registers");
endmodule
`default_nettype wire

// ---- rtl/fprs_pkg.sv ----
// Constants, types and field layout for the floating-point register stack.
// Functional notes
// - Eight data registers, eighty bits each.
// - Loads convert to extended format unless already.
// - Stores keep extended or convert as selected.
// - Register references resolve relative to stack top.
// - Top pointer sits in status bits 11-13.
// - Push load: decrement pointer, then write.
// - Pop store: read top, then increment pointer.
// - Push at pointer zero wraps to seven.
// - Index i selects top plus i, modulo eight.
// - Loads and stores without moving the pointer.
// - Overflow fault when push would overwrite value.
// - Sixteen-bit status word with all documented flags; C0, C2 and C3 are tied to zero.
// - Status word copied to memory or accumulator.
// - Swap exchanges stack top with relative register.
// - Packed-integer view aliases the same registers.
// - Stack state independent of other execution state.
// - Wide and compatibility modes behave like protected.
// - Condition bit one: overflow 1, underflow 0.
package fprs_pkg;
   // ----------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------
   localparam int DEPTH   = 8;             // Number of data registers.
   localparam int PTR_W   = 3;             // Width of the top pointer.
   localparam int DATA_W  = 80;            // Extended format width.
   localparam int MEM_W   = 80;            // Memory-side operand width.
   localparam int SW_W    = 16;            // Status word width.
   localparam int PK_W    = 64;            // Packed-integer view width.
   localparam int EXP_W   = 15;            // Extended exponent width.
   localparam int MANT_W  = 64;            // Extended significand width.
   localparam int FRAC_W  = 63;            // Fraction below integer bit.
   localparam int INT_W   = 64;            // Integer operand width.
   localparam int SGL_W   = 32;            // Single format width.
   localparam int DBL_W   = 64;            // Double format width.
   // ----------------------------------------------------------------
   // Status word fields
   // ----------------------------------------------------------------
   localparam int SW_IE   = 0;             // Invalid operation flag.
   localparam int SW_EXC_W = 6;            // Exception flags 0..5.
   localparam int SW_SF   = 6;             // Stack fault flag.
   localparam int SW_ES   = 7;             // Error summary.
   localparam int SW_C0   = 8;             // Condition bit zero.
   localparam int SW_C1   = 9;             // Condition bit one.
   localparam int SW_C2   = 10;            // Condition bit two.
   localparam int SW_TOP_LO = 11;          // Top pointer low bit.
   localparam int SW_TOP_HI = 13;          // Top pointer high bit.
   localparam int SW_C3   = 14;            // Condition bit three.
   localparam int SW_B    = 15;            // Busy flag mirrors summary.
   localparam logic [PTR_W-1:0] TOP_RST = 3'h0;     // Pointer at reset.
   localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;     // Pointer step.
   localparam logic [SW_EXC_W-1:0] EXC_RST = 6'h00; // Flags at reset.
   localparam logic [DEPTH-1:0] TAG_EMPTY = 8'h00;  // All registers empty.
   localparam logic [SW_EXC_W-1:0] IE_BIT = 6'h01;  // Invalid flag mask.
   // ----------------------------------------------------------------
   // Operand formats and biases
   // ----------------------------------------------------------------
   localparam logic [EXP_W-1:0] EXT_BIAS = 15'h3fff; // Extended bias.
   localparam logic [EXP_W-1:0] SGL_ADJ  = 15'h3f80; // Ext minus single.
   localparam logic [EXP_W-1:0] DBL_ADJ  = 15'h3c00; // Ext minus double.
   localparam logic [EXP_W-1:0] EXP_MAX  = 15'h7fff; // Extended inf/NaN.
   localparam logic [EXP_W-1:0] INT_TOP  = 15'h003e; // Largest in range.
   localparam logic [EXP_W-1:0] INT_MSB  = 15'h003f; // Weight of bit 63.
   typedef enum logic [1:0] {
      FPRS_FMT_EXT, FPRS_FMT_DBL, FPRS_FMT_SGL, FPRS_FMT_INT
   } fprs_fmt_t;
   typedef enum logic [2:0] {
      FPRS_OP_NONE,    // Idle.
      FPRS_OP_PUSH,    // Push load.
      FPRS_OP_POP,     // Pop store.
      FPRS_OP_LOAD,    // Load into relative register, no pointer move.
      FPRS_OP_STORE,   // Store from relative register, no pointer move.
      FPRS_OP_SWAP,    // Exchange top with relative register.
      FPRS_OP_STSW,    // Copy status word out.
      FPRS_OP_CLEX     // Clear exception flags.
   } fprs_op_t;
endpackage

// ---- rtl/fprs_cnv_if.sv ----
// Interface carrying operands between the stack and its format converter.
`timescale 1ns/1ps
`default_nettype none
interface fprs_cnv_if;
   import fprs_pkg::*;
   logic [MEM_W-1:0]  ld_raw;   // Memory operand on its way in.
   fprs_fmt_t         ld_fmt;   // Format of the inbound operand.
   logic [DATA_W-1:0] ld_ext;   // Inbound operand in extended format.
   logic [DATA_W-1:0] st_ext;   // Outbound operand in extended format.
   fprs_fmt_t         st_fmt;   // Format wanted on the way out.
   logic [MEM_W-1:0]  st_raw;   // Outbound operand in memory format.
   modport stack (output ld_raw, ld_fmt, st_ext, st_fmt,
                  input ld_ext, st_raw);
   modport conv  (input ld_raw, ld_fmt, st_ext, st_fmt,
                  output ld_ext, st_raw);
endinterface
`default_nettype wire

// ---- rtl/fprs_conv.sv ----
// Combinational format converter between memory operands and the stack.
`timescale 1ns/1ps
`default_nettype none
module fprs_conv
   import fprs_pkg::*;
(
   fprs_cnv_if.conv cv
);
   // ----------------------------------------------------------------
   // Inbound conversion to extended format.
   // ----------------------------------------------------------------
   // Widening is exact; denormal inputs are passed with a raw exponent.
   always_comb begin
      logic [INT_W-1:0] mag;
      logic [5:0]       lz;
      mag = '0;
      lz  = '0;
      cv.ld_ext = cv.ld_raw;
      case (cv.ld_fmt)
         FPRS_FMT_EXT: begin
            cv.ld_ext = cv.ld_raw;
         end
         FPRS_FMT_DBL: begin
            cv.ld_ext = {cv.ld_raw[DBL_W-1],
                         (cv.ld_raw[62:52] == 11'h000) ? 15'h0000 :
                         (cv.ld_raw[62:52] == 11'h7ff) ? EXP_MAX :
                         15'({4'h0, cv.ld_raw[62:52]} + DBL_ADJ),
                         (cv.ld_raw[62:52] != 11'h000),
                         cv.ld_raw[51:0], 11'h000};
         end
         FPRS_FMT_SGL: begin
            cv.ld_ext = {cv.ld_raw[SGL_W-1],
                         (cv.ld_raw[30:23] == 8'h00) ? 15'h0000 :
                         (cv.ld_raw[30:23] == 8'hff) ? EXP_MAX :
                         15'({7'h00, cv.ld_raw[30:23]} + SGL_ADJ),
                         (cv.ld_raw[30:23] != 8'h00),
                         cv.ld_raw[22:0], 40'h0000000000};
         end
         default: begin
            // Integer: normalise the magnitude by its leading one.
            mag = cv.ld_raw[INT_W-1] ? (~cv.ld_raw[INT_W-1:0] + 64'h1)
                                     : cv.ld_raw[INT_W-1:0];
            for (int k = 0; k < INT_W; k++) begin
               if (mag[k]) begin
                  lz = 6'(INT_W - 1 - k);
               end
            end
            cv.ld_ext = (mag == '0) ? '0 :
                        {cv.ld_raw[INT_W-1],
                         15'(EXT_BIAS + INT_MSB - {9'h000, lz}),
                         mag << lz};
         end
      endcase
   end
   // ----------------------------------------------------------------
   // Outbound conversion from extended format (truncating).
   // ----------------------------------------------------------------
   always_comb begin
      logic [EXP_W-1:0] e;
      e = cv.st_ext[78:64];
      cv.st_raw = cv.st_ext;
      case (cv.st_fmt)
         FPRS_FMT_EXT: begin
            cv.st_raw = cv.st_ext;
         end
         FPRS_FMT_DBL: begin
            cv.st_raw = {16'h0000, cv.st_ext[79],
                         (e == EXP_MAX) ? 11'h7ff :
                         (e <= DBL_ADJ) ? 11'h000 : 11'(e - DBL_ADJ),
                         cv.st_ext[62:11]};
         end
         FPRS_FMT_SGL: begin
            cv.st_raw = {48'h000000000000, cv.st_ext[79],
                         (e == EXP_MAX) ? 8'hff :
                         (e <= SGL_ADJ) ? 8'h00 : 8'(e - SGL_ADJ),
                         cv.st_ext[62:40]};
         end
         default: begin
            // Integer: truncate toward zero; out of range of either sign returns only bit 63 set.
            if (e < EXT_BIAS) begin
               cv.st_raw = '0;
            end else if (e > EXT_BIAS + INT_TOP) begin
               cv.st_raw = {16'h0000, 1'b1, 63'h0};
            end else begin
               cv.st_raw = {16'h0000, cv.st_ext[79] ?
                  64'(~(cv.st_ext[63:0] >> (EXT_BIAS + INT_MSB - e)) + 64'h1)
                  : 64'(cv.st_ext[63:0] >> (EXT_BIAS + INT_MSB - e))};
            end
         end
      endcase
   end
endmodule
`default_nettype wire

// ---- tb/fprs_core_mdl.sv ----
// Core-side model that collects operands the stack sends out.
`timescale 1ns/1ps
`default_nettype none
module fprs_core_mdl
   import fprs_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             mem_rvalid,
   input  wire logic [MEM_W-1:0] mem_rdata,
   output logic [MEM_W-1:0]      last_store
);
   // Keeps the latest outbound operand, taken only while it is valid.
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         last_store <= '0;
      end else if (mem_rvalid) begin
         last_store <= mem_rdata;
      end
   end
endmodule
`default_nettype wire

// ---- tb/fp_register_stack_tb.sv ----
// Self-checking bench for the floating-point register stack.
`timescale 1ns/1ps
`default_nettype none
module fp_register_stack_tb
   import fprs_pkg::*;
;
   localparam logic [79:0] VA = 80'h4000c000000000000000; // Operand A.
   localparam logic [79:0] VB = 80'hbfff8000000000000000; // Operand B.
   localparam logic [79:0] VC = 80'h3ffe8000000000000000; // Operand C.
   localparam logic [63:0] VD = 64'h0123456789abcdef;     // Packed data.
   localparam logic [79:0] ONE = 80'h3fff8000000000000000; // Ext one.
   localparam logic [79:0] D1 = 80'h00003ff0000000000000; // Double one.
   logic mclk, rst, mem_rvalid, acc_wr, sfe, pk_wr, mode_wide;
   fprs_op_t op;                          // Operation driven.
   fprs_fmt_t fmt;                        // Memory format driven.
   logic [2:0] rel_idx, pk_idx;           // Indices driven.
   logic [79:0] mem_wdata, mem_rdata, last_store;
   logic [15:0] sw, acc;                  // Status and its copy.
   logic [63:0] pk_wdata, pk_rdata;       // Packed view data.
   int err_count, check_count;            // Mismatches and checks.
   fprs_stack uut (.mclk(mclk), .rst(rst), .op(op), .rel_idx(rel_idx),
      .fmt(fmt), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_rvalid(mem_rvalid), .fp_status_word(sw),
      .integer_accumulator(acc), .acc_wr(acc_wr),
      .stack_fault_exception(sfe), .pk_wr(pk_wr), .pk_idx(pk_idx),
      .pk_wdata(pk_wdata), .pk_rdata(pk_rdata),
      .mode_wide(mode_wide));
   fprs_core_mdl core (.mclk(mclk), .rst(rst), .mem_rvalid(mem_rvalid),
      .mem_rdata(mem_rdata), .last_store(last_store));
   // Free-running core clock.
   always #5 mclk = ~mclk;
   // Presents one operation at a falling edge for one rising edge.
   task automatic go(input fprs_op_t o, input logic [2:0] i,
                     input logic [79:0] d);
      op = o;
      rel_idx = i;
      mem_wdata = d;
      @(negedge mclk);
   endtask
   // Compares a seen value with the expected one.
   task automatic chk(input string n, input logic [79:0] g,
                      input logic [79:0] e);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s exp %h got %h", n, e, g);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      repeat (2000) @(posedge mclk);
      err_count++;
      tally_and_finish();
   end
   // Main test sequence.
   initial begin
      mclk = 1'b0; rst = 1'b1; op = FPRS_OP_NONE; fmt = FPRS_FMT_EXT;
      rel_idx = 3'h0; mem_wdata = '0; pk_wr = 1'b0; pk_idx = 3'h0;
      pk_wdata = '0; mode_wide = 1'b0;
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      chk("sw", sw, 80'h0);
      go(FPRS_OP_STSW, 3'h0, 80'h0);
      chk("acc_wr", acc_wr, 80'h1);
      chk("acc", acc, 80'h0);
      go(FPRS_OP_PUSH, 3'h0, VA);
      chk("top", sw[13:11], 80'h7);
      go(FPRS_OP_PUSH, 3'h0, VB);
      chk("top", sw[13:11], 80'h6);
      go(FPRS_OP_POP, 3'h0, 80'h0);
      chk("pop", mem_rdata, VB);
      chk("rvalid", mem_rvalid, 80'h1);
      chk("top", sw[13:11], 80'h7);
      $display("test push_pop done");
      go(FPRS_OP_PUSH, 3'h0, VB);
      go(FPRS_OP_STORE, 3'h1, 80'h0);
      chk("rel1", mem_rdata, VA);
      chk("top", sw[13:11], 80'h6);
      go(FPRS_OP_SWAP, 3'h1, 80'h0);
      go(FPRS_OP_STORE, 3'h0, 80'h0);
      chk("swap0", mem_rdata, VA);
      go(FPRS_OP_STORE, 3'h1, 80'h0);
      chk("swap1", mem_rdata, VB);
      go(FPRS_OP_LOAD, 3'h2, VC);
      go(FPRS_OP_STORE, 3'h2, 80'h0);
      chk("load", mem_rdata, VC);
      go(FPRS_OP_NONE, 3'h0, 80'h0);
      pk_wr = 1'b1; pk_idx = 3'h6; pk_wdata = VD;
      @(negedge mclk);
      pk_wr = 1'b0;
      chk("packed", pk_rdata, VD);
      go(FPRS_OP_STORE, 3'h0, 80'h0);
      chk("alias", mem_rdata[63:0], VD);
      $display("test relative done");
      repeat (5) go(FPRS_OP_PUSH, 3'h0, VA);
      go(FPRS_OP_PUSH, 3'h0, VC);
      chk("ovf", sfe, 80'h1);
      chk("top", sw[13:11], 80'h1);
      chk("c1", sw[9], 80'h1);
      chk("flags", {sw[6], sw[0]}, 80'h3);
      go(FPRS_OP_STSW, 3'h0, 80'h0);
      chk("acc_top", acc[13:11], 80'h1);
      chk("acc_all", acc, 80'h8ac1);
      chk("sw_mem", mem_rdata, 80'h8ac1);
      go(FPRS_OP_CLEX, 3'h0, 80'h0);
      chk("clex", sw[5:0], 80'h0);
      repeat (8) go(FPRS_OP_POP, 3'h0, 80'h0);
      chk("last", mem_rdata, VC);
      go(FPRS_OP_POP, 3'h0, 80'h0);
      chk("unf", {sfe, mem_rvalid, sw[9]}, 80'h4);
      $display("test faults done");
      mode_wide = 1'b1;
      fmt = FPRS_FMT_DBL;
      go(FPRS_OP_PUSH, 3'h0, D1);
      fmt = FPRS_FMT_EXT;
      go(FPRS_OP_POP, 3'h0, 80'h0);
      chk("cnv_in", mem_rdata, ONE);
      go(FPRS_OP_PUSH, 3'h0, ONE);
      fmt = FPRS_FMT_DBL;
      go(FPRS_OP_POP, 3'h0, 80'h0);
      go(FPRS_OP_NONE, 3'h0, 80'h0);
      chk("cnv_out", last_store[63:0], D1);
      fmt = FPRS_FMT_SGL;
      go(FPRS_OP_PUSH, 3'h0, 80'h3f800000);
      fmt = FPRS_FMT_EXT;
      go(FPRS_OP_POP, 3'h0, 80'h0);
      chk("sgl_in", mem_rdata, ONE);
      go(FPRS_OP_PUSH, 3'h0, ONE);
      fmt = FPRS_FMT_SGL;
      go(FPRS_OP_POP, 3'h0, 80'h0);
      chk("sgl_out", mem_rdata, 80'h3f800000);
      fmt = FPRS_FMT_INT;
      go(FPRS_OP_PUSH, 3'h0, 80'h5);
      fmt = FPRS_FMT_EXT;
      go(FPRS_OP_POP, 3'h0, 80'h0);
      chk("int_in", mem_rdata, 80'h4001a000000000000000);
      go(FPRS_OP_PUSH, 3'h0, 80'h4001a000000000000000);
      fmt = FPRS_FMT_INT;
      go(FPRS_OP_POP, 3'h0, 80'h0);
      chk("int_out", mem_rdata, 80'h5);
      $display("test formats done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
